// *** rtl/otd_defs.svh ***
`ifndef OTD_DEFS_SVH
`define OTD_DEFS_SVH

// register map, byte addresses
`define OTD_ADDR_W          8
`define OTD_DATA_W          32
`define OTD_OFF_FIRST_ON    8'h00
`define OTD_OFF_FIRST_OFF   8'h04
`define OTD_OFF_SECOND_ON   8'h08
`define OTD_OFF_SECOND_OFF  8'h0c
`define OTD_OFF_RELAY_ON    8'h10
`define OTD_OFF_RELAY_OFF   8'h14
`define OTD_OFF_CTRL        8'h18
`define OTD_OFF_STAT        8'h1c
`define OTD_DLY_STRIDE      8'h08
`define OTD_DLY_OFF_STEP    8'h04

// delay settings, tenths of a second
`define OTD_DLY_W           10
`define OTD_DLY_MAX         10'h3e8
`define OTD_DLY_RST         10'h000

// control and status fields
`define OTD_CTRL_RST        3'h0
`define OTD_STAT_SRC_LSB    0
`define OTD_STAT_OUT_LSB    4

// timing: one setting step is 0.1 s, clock period 25 ns
`define OTD_STEP_NS         100000000
`define OTD_CLK_NS          25
`define OTD_N_OUT           3
`define OTD_N_OC            2
`define OTD_RELAY_IDX       2

`endif

// *** rtl/otd_pkg.sv ***
package otd_pkg;
  typedef logic [9:0]  dly_t;   // delay setting in tenths of a second
  typedef logic [31:0] cnt_t;   // cycle count
  typedef logic [7:0]  addr_t;  // register byte address
  typedef logic [31:0] word_t;  // register data word
  typedef enum logic [0:0] {
    SRC_FUNC,
    SRC_RUN
  } src_sel_e;
endpackage : otd_pkg

// *** rtl/dly_chan_if.sv ***
interface dly_chan_if;
  import otd_pkg::*;
  logic src;     // undelayed function level, active high
  cnt_t on_tgt;  // rising delay in clock cycles
  cnt_t off_tgt; // falling delay in clock cycles
  logic out;     // delayed level, active high

  modport ctl (output src, output on_tgt, output off_tgt, input out);
  modport chan (input src, input on_tgt, input off_tgt, output out);
endinterface : dly_chan_if

// *** rtl/dly_chan.sv ***
module dly_chan (
  input  wire logic  clk_sys, // system clock
  input  wire logic  rst,     // async reset, active high
  dly_chan_if.chan   ch       // source, targets, delayed level
);
  import otd_pkg::*;

  cnt_t held_ff;
  cnt_t nxt_held;
  logic out_ff;
  logic nxt_out;
  cnt_t tgt;
  logic due;

  // target for the pending transition direction
  assign tgt = ch.src ? ch.on_tgt : ch.off_tgt; // RQ5
  assign due = (tgt == '0) || (held_ff == tgt - 32'h1); // RQ10

  // hold counter restarts whenever source matches output
  always_comb begin
    nxt_held = '0;
    if (ch.src != out_ff) begin
      nxt_held = (held_ff == '1) ? held_ff : held_ff + 32'h1; // RQ10
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      held_ff <= '0;
    end else begin
      held_ff <= nxt_held;
    end
  end

  // output follows only once the new level is held long enough
  always_comb begin
    nxt_out = out_ff;
    if ((ch.src != out_ff) && due) begin
      nxt_out = ch.src; // RQ3 RQ4
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      out_ff <= 1'b0;
    end else begin
      out_ff <= nxt_out;
    end
  end

  assign ch.out = out_ff;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  sequence s_rise_pending;
    ch.src && !out_ff;
  endsequence

  sequence s_fall_pending;
    !ch.src && out_ff;
  endsequence

  property p_no_short_pulse;
    !ch.src && !out_ff |=> !out_ff;
  endproperty
  a_no_short_pulse: assert property (p_no_short_pulse) else $error("output rose without source"); // RQ3

  property p_rise_timed;
    s_rise_pending and (held_ff + 32'h1 < ch.on_tgt) |=> !out_ff;
  endproperty
  a_rise_timed: assert property (p_rise_timed) else $error("output rose before on delay"); // RQ3

  property p_gap_bridged;
    ch.src && out_ff |=> out_ff;
  endproperty
  a_gap_bridged: assert property (p_gap_bridged) else $error("output fell while source high"); // RQ4

  property p_fall_timed;
    s_fall_pending and (held_ff + 32'h1 < ch.off_tgt) |=> out_ff;
  endproperty
  a_fall_timed: assert property (p_fall_timed) else $error("output fell before off delay"); // RQ4

  property p_zero_pass;
    (ch.src != out_ff) && (tgt == '0) |=> (out_ff == $past(ch.src));
  endproperty
  a_zero_pass: assert property (p_zero_pass) else $error("zero delay did not pass edge"); // RQ10

  property p_restart;
    ch.src == out_ff |=> held_ff == '0;
  endproperty
  a_restart: assert property (p_restart) else $error("hold counter not restarted"); // RQ10
endmodule : dly_chan

// *** rtl/output_transition_delay.sv ***
// Functional notes
// RQ1: each of three outputs has own delays
// RQ2: delays span 0.1 to 100.0 seconds
// RQ3: rising edge delayed, short pulses suppressed
// RQ4: falling edge delayed, short gaps bridged
// RQ5: both delays apply to their edges
// RQ6: six settings, range 0 to 100.0, default 0
// RQ7: delays combine with any assigned function
// RQ8: run indicator asserted while motor driven
// RQ9: run indicator active low, open collector
// RQ10: restartable hold counter, zero passes immediately
//
// The plain strobed port and the placing of the registers were chosen for this implementation.
`include "otd_defs.svh"

module output_transition_delay #(
  parameter int unsigned STEP_CYCLES = `OTD_STEP_NS / `OTD_CLK_NS // cycles per 0.1 s
) (
  input  wire logic          clk_sys,    // system clock, 40 MHz
  input  wire logic          rst,        // async reset, active high
  input  wire otd_pkg::addr_t addr,      // register byte address
  input  wire otd_pkg::word_t wdata,     // register write data
  input  wire logic          wr_stb,     // write strobe
  input  wire logic          rd_stb,     // read strobe
  output      otd_pkg::word_t rdata,     // read data, cycle after strobe
  input  wire logic          run_active, // motor being driven
  input  wire logic [2:0]    fn_src,     // other assigned functions per output
  output      logic [1:0]    oc_out,     // open-collector level when driven
  output      logic [1:0]    oc_oe_n,    // open-collector enable, low sinks
  output      logic          relay_coil  // relay coil drive, active high
);
  import otd_pkg::*;

  localparam int unsigned NOUT = `OTD_N_OUT;
  localparam int unsigned NOC  = `OTD_N_OC;
  localparam int unsigned RLY  = `OTD_RELAY_IDX;

  dly_t             dly_ff [2*NOUT];
  logic [NOUT-1:0]  sel_ff;
  word_t            rdata_ff;
  word_t            nxt_rdata;
  logic [NOUT-1:0]  src;
  logic [NOUT-1:0]  dout;
  logic [NOC-1:0]   oe_n_ff;
  logic             coil_ff;
  cnt_t             on_tgt [NOUT];
  cnt_t             off_tgt [NOUT];

  // write to one delay setting, clamped to 100.0 s
  genvar gi;
  generate
    for (gi = 0; gi < 2*NOUT; gi++) begin : g_dly
      localparam addr_t OFF = addr_t'(gi * `OTD_DLY_OFF_STEP);
      always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
          dly_ff[gi] <= `OTD_DLY_RST; // RQ6
        end else if (wr_stb && addr == OFF) begin
          if (wdata[`OTD_DLY_W-1:0] > `OTD_DLY_MAX || |wdata[31:`OTD_DLY_W]) begin
            dly_ff[gi] <= `OTD_DLY_MAX; // RQ2 RQ6
          end else begin
            dly_ff[gi] <= wdata[`OTD_DLY_W-1:0];
          end
        end
      end

      // each setting moves only on its own write
      property p_dly_keep;
        @(posedge clk_sys) disable iff (rst)
        !(wr_stb && addr == OFF) |=> $stable(dly_ff[gi]);
      endproperty
      a_dly_keep: assert property (p_dly_keep) else $error("delay setting changed without write"); // RQ6

      property p_dly_load;
        @(posedge clk_sys) disable iff (rst)
        wr_stb && addr == OFF && wdata <= 32'(`OTD_DLY_MAX) |=> dly_ff[gi] == $past(wdata[`OTD_DLY_W-1:0]);
      endproperty
      a_dly_load: assert property (p_dly_load) else $error("delay write not stored"); // RQ6

      property p_dly_clamp;
        @(posedge clk_sys) disable iff (rst)
        wr_stb && addr == OFF && wdata > 32'(`OTD_DLY_MAX) |=> dly_ff[gi] == `OTD_DLY_MAX;
      endproperty
      a_dly_clamp: assert property (p_dly_clamp) else $error("oversized delay not clamped"); // RQ2
    end
  endgenerate

  // source selection register
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      sel_ff <= `OTD_CTRL_RST;
    end else if (wr_stb && addr == `OTD_OFF_CTRL) begin
      sel_ff <= wdata[NOUT-1:0];
    end
  end

  // read mux
  always_comb begin
    nxt_rdata = '0;
    case (addr)
      `OTD_OFF_FIRST_ON:   nxt_rdata = {22'h0, dly_ff[0]};
      `OTD_OFF_FIRST_OFF:  nxt_rdata = {22'h0, dly_ff[1]};
      `OTD_OFF_SECOND_ON:  nxt_rdata = {22'h0, dly_ff[2]};
      `OTD_OFF_SECOND_OFF: nxt_rdata = {22'h0, dly_ff[3]};
      `OTD_OFF_RELAY_ON:   nxt_rdata = {22'h0, dly_ff[4]};
      `OTD_OFF_RELAY_OFF:  nxt_rdata = {22'h0, dly_ff[5]};
      `OTD_OFF_CTRL:       nxt_rdata = {29'h0, sel_ff};
      `OTD_OFF_STAT:       nxt_rdata = {25'h0, dout, 1'b0, src};
      default:             nxt_rdata = '0;
    endcase
  end

  // read data stand only in the cycle after the strobe
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rdata_ff <= '0;
    end else if (rd_stb) begin
      rdata_ff <= nxt_rdata;
    end else begin
      rdata_ff <= '0;
    end
  end

  assign rdata = rdata_ff;

  // one delay channel per output
  generate
    for (gi = 0; gi < NOUT; gi++) begin : g_chan
      dly_chan_if chif ();
      // any function may feed the delays
      assign src[gi] = (sel_ff[gi] == SRC_RUN) ? run_active : fn_src[gi]; // RQ7 RQ8
      assign on_tgt[gi]  = 32'(dly_ff[2*gi]) * 32'(STEP_CYCLES); // RQ1
      assign off_tgt[gi] = 32'(dly_ff[2*gi+1]) * 32'(STEP_CYCLES); // RQ1
      assign chif.src     = src[gi];
      assign chif.on_tgt  = on_tgt[gi];
      assign chif.off_tgt = off_tgt[gi];
      assign dout[gi]     = chif.out;
      dly_chan u_chan (
        .clk_sys (clk_sys),
        .rst     (rst),
        .ch      (chif)
      );
    end
  endgenerate

  // open-collector pins sink to ground when asserted
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      oe_n_ff <= '1;
    end else begin
      oe_n_ff <= ~dout[NOC-1:0]; // RQ9
    end
  end

  // relay coil follows the third channel
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      coil_ff <= 1'b0;
    end else begin
      coil_ff <= dout[RLY];
    end
  end

  assign oc_out     = '0;
  assign oc_oe_n    = oe_n_ff;
  assign relay_coil = coil_ff;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  sequence s_wr_big;
    wr_stb && addr == `OTD_OFF_RELAY_OFF && wdata > 32'h3e8;
  endsequence

  property p_clamp;
    s_wr_big |=> dly_ff[5] == `OTD_DLY_MAX;
  endproperty
  a_clamp: assert property (p_clamp) else $error("delay not clamped"); // RQ2

  property p_dly_range;
    dly_ff[0] <= `OTD_DLY_MAX && dly_ff[3] <= `OTD_DLY_MAX;
  endproperty
  a_dly_range: assert property (p_dly_range) else $error("delay setting out of range"); // RQ6

  property p_wr_store;
    wr_stb && addr == `OTD_OFF_SECOND_ON && wdata < 32'h3e9 |=> dly_ff[2] == $past(wdata[9:0]);
  endproperty
  a_wr_store: assert property (p_wr_store) else $error("delay write lost"); // RQ6

  property p_run_src;
    sel_ff[0] == SRC_RUN |-> src[0] == run_active;
  endproperty
  a_run_src: assert property (p_run_src) else $error("run indicator not routed"); // RQ8

  property p_func_src;
    sel_ff[1] == SRC_FUNC |-> src[1] == fn_src[1];
  endproperty
  a_func_src: assert property (p_func_src) else $error("function source not routed"); // RQ7

  property p_oc_sink;
    dout[0] |=> !oc_oe_n[0];
  endproperty
  a_oc_sink: assert property (p_oc_sink) else $error("asserted output not sinking"); // RQ9

  property p_oc_release;
    !dout[1] |=> oc_oe_n[1] && oc_out[1] == 1'b0;
  endproperty
  a_oc_release: assert property (p_oc_release) else $error("inactive output still sinking"); // RQ9

  property p_relay;
    dout[RLY] |=> relay_coil;
  endproperty
  a_relay: assert property (p_relay) else $error("relay does not follow channel"); // RQ1

  property p_target;
    (on_tgt[1] == '0) == (dly_ff[2] == '0);
  endproperty
  a_target: assert property (p_target) else $error("on target mismatch"); // RQ5

  property p_rd;
    rd_stb && addr == `OTD_OFF_CTRL |=> rdata == {29'h0, $past(sel_ff)};
  endproperty
  a_rd: assert property (p_rd) else $error("control readback wrong"); // RQ7

  property p_rd_idle;
    !rd_stb |=> rdata == '0;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside read cycle");

  property p_zero_fast;
    sel_ff[2] == SRC_FUNC && dly_ff[4] == '0 && $rose(fn_src[2]) && !dout[2] |=> ##1 relay_coil;
  endproperty
  a_zero_fast: assert property (p_zero_fast) else $error("zero delay not immediate"); // RQ10

  // register bus checks
  property p_sel_load;
    wr_stb && addr == `OTD_OFF_CTRL |=> sel_ff == $past(wdata[NOUT-1:0]);
  endproperty
  a_sel_load: assert property (p_sel_load) else $error("source select write lost"); // RQ7

  property p_sel_keep;
    !(wr_stb && addr == `OTD_OFF_CTRL) |=> $stable(sel_ff);
  endproperty
  a_sel_keep: assert property (p_sel_keep) else $error("source select changed without write"); // RQ7

  property p_rd_stat;
    rd_stb && addr == `OTD_OFF_STAT |=> rdata[NOUT-1:0] == $past(src)
      && rdata[`OTD_STAT_OUT_LSB +: NOUT] == $past(dout);
  endproperty
  a_rd_stat: assert property (p_rd_stat) else $error("status readback wrong"); // RQ1

  property p_rd_dly;
    rd_stb && addr == `OTD_OFF_RELAY_OFF |=> rdata == 32'($past(dly_ff[5]));
  endproperty
  a_rd_dly: assert property (p_rd_dly) else $error("delay readback wrong"); // RQ6

  property p_rd_unmapped;
    rd_stb && addr > `OTD_OFF_STAT |=> rdata == '0;
  endproperty
  a_rd_unmapped: assert property (p_rd_unmapped) else $error("unmapped read not zero");

  // pin checks
  property p_oc_low;
    oc_out == '0;
  endproperty
  a_oc_low: assert property (p_oc_low) else $error("open collector level not ground"); // RQ9

  property p_oc_sink1;
    dout[1] |=> !oc_oe_n[1];
  endproperty
  a_oc_sink1: assert property (p_oc_sink1) else $error("second output not sinking"); // RQ9

  property p_oc_release0;
    !dout[0] |=> oc_oe_n[0];
  endproperty
  a_oc_release0: assert property (p_oc_release0) else $error("first output still sinking"); // RQ9

  property p_relay_drop;
    !dout[RLY] |=> !relay_coil;
  endproperty
  a_relay_drop: assert property (p_relay_drop) else $error("relay held without channel"); // RQ1

  property p_coil_rise;
    $rose(relay_coil) |-> $past(dout[RLY]);
  endproperty
  a_coil_rise: assert property (p_coil_rise) else $error("relay energised without channel"); // RQ1

  property p_coil_fall;
    $fell(relay_coil) |-> !$past(dout[RLY]);
  endproperty
  a_coil_fall: assert property (p_coil_fall) else $error("relay dropped while channel high"); // RQ1

  // source routing and off target checks
  property p_func_src0;
    sel_ff[0] == SRC_FUNC |-> src[0] == fn_src[0];
  endproperty
  a_func_src0: assert property (p_func_src0) else $error("first function source not routed"); // RQ7

  property p_run_src1;
    sel_ff[1] == SRC_RUN |-> src[1] == run_active;
  endproperty
  a_run_src1: assert property (p_run_src1) else $error("run indicator not on second output"); // RQ8

  property p_run_src2;
    sel_ff[RLY] == SRC_RUN |-> src[RLY] == run_active;
  endproperty
  a_run_src2: assert property (p_run_src2) else $error("run indicator not on relay"); // RQ8

  property p_off_target;
    (off_tgt[RLY] == '0) == (dly_ff[2*RLY+1] == '0);
  endproperty
  a_off_target: assert property (p_off_target) else $error("off target lost setting"); // RQ5
endmodule : output_transition_delay

// *** sim/load_model.sv ***
module load_model (
  input  wire logic [1:0] oc_out,     // level while sinking
  input  wire logic [1:0] oc_oe_n,    // low while sinking
  input  wire logic       relay_coil, // coil drive
  output      logic [1:0] oc_line,    // lines with external pull-up
  output      logic       relay_no    // normally open contact closed
);
  timeunit 1ns;
  timeprecision 100ps;
  // a released line is pulled up, a sinking one goes to ground
  assign oc_line[0] = oc_oe_n[0] ? 1'b1 : oc_out[0];
  assign oc_line[1] = oc_oe_n[1] ? 1'b1 : oc_out[1];
  // contact follows the energised coil
  assign relay_no = relay_coil;
endmodule : load_model

// *** sim/test_output_transition_delay.sv ***
`include "otd_defs.svh"

module test_output_transition_delay;
  timeunit 1ns;
  timeprecision 100ps;
  import otd_pkg::*;
  localparam int unsigned STEP = 4;
  logic       clk_sys;
  logic       rst;
  addr_t      addr;
  word_t      wdata;
  logic       wr_stb;
  logic       rd_stb;
  word_t      rdata;
  logic       run_active;
  logic [2:0] fn_src;
  logic [1:0] oc_out;
  logic [1:0] oc_oe_n;
  logic       relay_coil;
  logic [1:0] oc_line;
  logic       relay_no;
  int         mismatches;
  int         tests_run;

  output_transition_delay #(.STEP_CYCLES(STEP)) uut (
    .clk_sys(clk_sys), .rst(rst), .addr(addr), .wdata(wdata), .wr_stb(wr_stb),
    .rd_stb(rd_stb), .rdata(rdata), .run_active(run_active), .fn_src(fn_src),
    .oc_out(oc_out), .oc_oe_n(oc_oe_n), .relay_coil(relay_coil));

  load_model load (.oc_out(oc_out), .oc_oe_n(oc_oe_n), .relay_coil(relay_coil),
    .oc_line(oc_line), .relay_no(relay_no));

  // 40 MHz clock
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end

  // asserted level seen by the load on output i
  function automatic logic pin(input int i);
    pin = (i < 2) ? ~oc_line[i] : relay_no;
  endfunction : pin

  task automatic chk(input word_t got, input word_t exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input addr_t a, input word_t d);
    @(posedge clk_sys);
    addr   <= a;
    wdata  <= d;
    wr_stb <= 1'b1;
    @(posedge clk_sys);
    wr_stb <= 1'b0;
  endtask : wr

  // read data stands only in the cycle after the strobe
  task automatic rd(input addr_t a, input word_t exp);
    @(posedge clk_sys);
    addr   <= a;
    rd_stb <= 1'b1;
    @(posedge clk_sys);
    rd_stb <= 1'b0;
    #1 chk(rdata, exp);
  endtask : rd

  // drive a source edge, pin must move exactly max(t,1)+1 edges later
  task automatic edge_chk(input int i, input bit r, input logic v, input int t);
    @(posedge clk_sys);
    if (r) run_active <= v;
    else fn_src[i] <= v;
    repeat (t > 1 ? t : 1) @(posedge clk_sys);
    #1 chk({31'h0, pin(i)}, {31'h0, ~v});
    @(posedge clk_sys);
    #1 chk({31'h0, pin(i)}, {31'h0, v});
  endtask : edge_chk

  // source pulse of n cycles at level v, then back
  task automatic pulse(input int i, input logic v, input int n);
    @(posedge clk_sys);
    fn_src[i] <= v;
    repeat (n) @(posedge clk_sys);
    fn_src[i] <= ~v;
  endtask : pulse

  task automatic hold_chk(input int i, input logic v, input int n);
    repeat (n) begin
      @(posedge clk_sys);
      #1 chk({31'h0, pin(i)}, {31'h0, v});
    end
  endtask : hold_chk

  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : wrap_up

  // watchdog against a hang
  initial begin
    repeat (5000) @(posedge clk_sys);
    mismatches++;
    wrap_up();
  end

  // main sequence
  initial begin
    mismatches = 0;
    tests_run  = 0;
    rst        = 1'b1;
    addr       = 8'h00;
    wdata      = 32'h0;
    wr_stb     = 1'b0;
    rd_stb     = 1'b0;
    run_active = 1'b0;
    fn_src     = 3'h0;
    repeat (10) @(posedge clk_sys);
    #1 chk({29'h0, oc_oe_n, relay_coil}, {29'h0, 2'b11, 1'b0});
    @(posedge clk_sys);
    rst <= 1'b0;
    // defaults, status and one unmapped place all read zero
    for (int a = 0; a <= 8'h20; a += 4) rd(addr_t'(a), 32'h0);
    // relay with no delay follows two edges later
    edge_chk(2, 0, 1'b1, 0);
    edge_chk(2, 0, 1'b0, 0);
    wr(`OTD_OFF_RELAY_ON, 32'hffff);
    rd(`OTD_OFF_RELAY_ON, 32'h3e8);
    wr(`OTD_OFF_RELAY_ON, 32'h1);
    rd(`OTD_OFF_RELAY_ON, 32'h1);
    wr(`OTD_OFF_CTRL, 32'hffffffff);
    rd(`OTD_OFF_CTRL, 32'h7);
    wr(`OTD_OFF_CTRL, 32'h0);
    wr(8'h40, 32'h5);
    rd(8'h40, 32'h0);
    // zero delay passes at once
    edge_chk(0, 0, 1'b1, 0);
    edge_chk(0, 0, 1'b0, 0);
    // on delay 0.2 s: 7-cycle pulse dropped, long pulse shifted
    wr(`OTD_OFF_FIRST_ON, 32'h2);
    pulse(0, 1'b1, 7);
    hold_chk(0, 1'b0, 12);
    edge_chk(0, 0, 1'b1, 8);
    edge_chk(0, 0, 1'b0, 0);
    // off delay 0.1 s: 3-cycle gap bridged, fall stretched
    wr(`OTD_OFF_SECOND_OFF, 32'h1);
    edge_chk(1, 0, 1'b1, 0);
    pulse(1, 1'b0, 3);
    hold_chk(1, 1'b1, 8);
    edge_chk(1, 0, 1'b0, 4);
    // relay with both delays
    wr(`OTD_OFF_RELAY_OFF, 32'h2);
    pulse(2, 1'b1, 3);
    hold_chk(2, 1'b0, 8);
    edge_chk(2, 0, 1'b1, 4);
    edge_chk(2, 0, 1'b0, 8);
    // run indicator on first output, still with its on delay
    wr(`OTD_OFF_CTRL, 32'h1);
    edge_chk(0, 1, 1'b1, 8);
    chk({30'h0, oc_out}, 32'h0);
    chk({30'h0, oc_oe_n}, 32'h2);
    rd(`OTD_OFF_STAT, 32'h11);
    edge_chk(0, 1, 1'b0, 0);
    wrap_up();
  end
endmodule : test_output_transition_delay
